// *** bench/tb_fault_safe_state_config.sv ***
// Self-checking bench for the fault safe-state configuration block.
// Assumes the design's own assertions run alongside; inputs change on the falling edge.
`timescale 1ns/1ps
module tb_fault_safe_state_config;
  localparam int CLAMP_STEP = 100 / 5;
  logic                clk_sys_i, rst_b_i, rst_next, cfg_wr_i, gate_cmd_i, clamp_trigger_i;
  logic [15:0]         cfg_wdata_i, cfg_rdata_o, cfg_m, c;
  fss_pkg::fss_fault_t fault_i, fault_mask_i;
  logic                gate_source_output_o, gate_sink_output_o, safe_state_active_o, collector_voltage_clamp_o;
  logic [1:0]          exp;
  logic [31:0]         r, r2;
  int                  err_total, samples_checked, left, lsb;
  logic                chk_on;

  fss_fault_safe_state_config i_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o), .fault_i(fault_i), .fault_mask_i(fault_mask_i), .gate_cmd_i(gate_cmd_i),
    .clamp_trigger_i(clamp_trigger_i), .gate_source_output_o(gate_source_output_o),
    .gate_sink_output_o(gate_sink_output_o), .safe_state_active_o(safe_state_active_o),
    .collector_voltage_clamp_o(collector_voltage_clamp_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // Returns {source, safe}; low beats high beats no action, reserved fails low
  function automatic logic [1:0] ref_out(input logic [15:0] cf, input logic [6:0] act, input logic cmd);
    logic lo, hi;
    logic [1:0] code;
    lo = 1'b0;
    hi = 1'b0;
    for (int b = 0; b < 7; b++) begin
      code = cf[((b == 0) ? 0 : 2 * b + 2) +: 2];
      if (act[b] && (code == 2'h0 || code == 2'h2)) lo = 1'b1;
      if (act[b] && code == 2'h1) hi = 1'b1;
    end
    return lo ? 2'b01 : (hi ? 2'b11 : {cmd, 1'b0});
  endfunction

  task automatic cmp_reg(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_bit(input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic step(input logic w, input logic [15:0] d, input logic [6:0] f, input logic [6:0] m,
                      input logic cmd, input logic t);
    @(negedge clk_sys_i);
    if (chk_on) begin
      cmp_reg(cfg_m, cfg_rdata_o);
      cmp_bit(exp[1], gate_source_output_o);
      cmp_bit(~exp[1], gate_sink_output_o);
      cmp_bit(exp[0], safe_state_active_o);
      cmp_bit(left != 0, collector_voltage_clamp_o);
    end
    if (left != 0) left--;
    // Reset moves with the other inputs so this step's expectation sees it
    rst_b_i = rst_next;
    cfg_wr_i = w;
    cfg_wdata_i = d;
    fault_i = fss_pkg::fss_fault_t'(f);
    fault_mask_i = fss_pkg::fss_fault_t'(m);
    gate_cmd_i = cmd;
    clamp_trigger_i = t;
    exp = ref_out(cfg_m, f & ~m, cmd);
    if (t) left = (int'(cfg_m[3:2]) + 1) * CLAMP_STEP;
    if (w) cfg_m = d;
    // Reset wins over everything launched at the same edge
    if (rst_b_i === 1'b0) begin
      exp = 2'b00;
      left = 0;
      cfg_m = 16'h0000;
    end
  endtask

  task automatic end_of_test();
    $display("err_total=%0d samples_checked=%0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #(20000 * 5);
    err_total++;
    end_of_test();
  end

  initial begin
    {rst_b_i, rst_next, chk_on, cfg_wr_i, gate_cmd_i, clamp_trigger_i} = 6'h00;
    cfg_wdata_i = 16'h0000;
    fault_i = '0;
    fault_mask_i = '0;
    {err_total, samples_checked, left, cfg_m, exp} = '0;
    r = 32'h8a975ead;
    step(1'b0, 16'h0000, 7'h00, 7'h00, 1'b0, 1'b0);
    chk_on = 1'b1;
    repeat (6) step(1'b0, 16'h0000, 7'h00, 7'h00, 1'b0, 1'b0);
    rst_next = 1'b1;
    // Reset value: every fault pulls low, shortest clamp hold
    for (int b = 0; b < 7; b++) step(1'b0, 16'h0000, 7'h01 << b, 7'h00, 1'b1, b == 0);
    // Each fault alone with every action code, then masked
    for (int b = 0; b < 7; b++) begin
      for (int k = 0; k < 4; k++) begin
        lsb = (b == 0) ? 0 : 2 * b + 2;
        c = 16'hffff;
        c[lsb +: 2] = k[1:0];
        step(1'b1, c, 7'h00, 7'h00, 1'b1, 1'b0);
        step(1'b0, c, 7'h01 << b, 7'h00, 1'b1, 1'b0);
        step(1'b0, c, 7'h01 << b, 7'h00, 1'b0, 1'b0);
        step(1'b0, c, 7'h01 << b, 7'h01 << b, 1'b0, 1'b0);
      end
    end
    // Every clamp hold selection run to its end
    for (int k = 0; k < 4; k++) begin
      step(1'b1, {12'h000, k[1:0], 2'h3}, 7'h00, 7'h00, 1'b0, 1'b0);
      step(1'b0, 16'h0000, 7'h00, 7'h00, 1'b0, 1'b1);
      repeat (85) step(1'b0, 16'h0000, 7'h00, 7'h00, 1'b1, 1'b0);
    end
    for (int i = 0; i < 3000; i++) begin
      r = lfsr(r);
      r2 = lfsr(r);
      r = lfsr(r2);
      if (i == 1500) rst_next = 1'b0;
      if (i == 1502) rst_next = 1'b1;
      step(r[3:0] == 4'h0, r2[31:16], r[6:0] & r[13:7] & r2[6:0], r[22:16] & r2[13:7], r[28], r2[21:16] == 6'h00);
    end
    step(1'b0, 16'h0000, 7'h00, 7'h00, 1'b0, 1'b0);
    end_of_test();
  end
endmodule

// *** logic/fss_fault_safe_state_config.sv ***
// Fault safe-state configuration register and gate output steering of the secondary side.
// Assumes fault, mask and clamp trigger inputs come from logic on clk_sys_i (no synchroniser).
// Operation
// - Positive supply undervoltage, unmasked: outputs follow bits 15-14 action.
// - Positive supply overvoltage, unmasked: outputs follow bits 13-12 action.
// - Negative supply undervoltage, unmasked: outputs follow bits 11-10 action.
// - Negative supply overvoltage, unmasked: outputs follow bits 9-8 action.
// - Trim data CRC fault, unmasked: outputs follow bits 7-6 action.
// - Configuration CRC fault, unmasked: outputs follow bits 5-4 action.
// - Voltage clamp held 100, 200, 300 or 400 ns per bits 3-2.
// - Clock monitor fault, unmasked: outputs follow bits 1-0 action.
// - Register resets to zero: faults force low, shortest clamp hold.
`timescale 1ns/1ps
module fss_fault_safe_state_config (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_b_i,
  input  wire logic               cfg_wr_i,
  input  wire logic [15:0]        cfg_wdata_i,
  output logic      [15:0]        cfg_rdata_o,
  input  wire fss_pkg::fss_fault_t fault_i,
  input  wire fss_pkg::fss_fault_t fault_mask_i,
  input  wire logic               gate_cmd_i,
  input  wire logic               clamp_trigger_i,
  output logic                    gate_source_output_o,
  output logic                    gate_sink_output_o,
  output logic                    safe_state_active_o,
  output logic                    collector_voltage_clamp_o
);

  fss_pkg::fss_cfg_t                         cfg;
  fss_pkg::fss_fault_t                       active;
  logic [fss_pkg::FAULT_N-1:0][1:0]          act;
  logic                                      any_low;
  logic                                      any_high;
  logic [fss_pkg::CLAMP_CNT_W-1:0]           clamp_cnt;
  logic [fss_pkg::CLAMP_CNT_W-1:0]           next_clamp_cnt;

  function automatic logic [fss_pkg::CLAMP_CNT_W-1:0] hold_cycles(input logic [1:0] sel);
    hold_cycles = fss_pkg::CLAMP_CNT_W'((int'(sel) + 1) * fss_pkg::CLAMP_STEP_CYC);
  endfunction

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cfg <= fss_pkg::fss_cfg_t'(fss_pkg::CFG_RESET);
    end else if (cfg_wr_i) begin
      cfg <= fss_pkg::fss_cfg_t'(cfg_wdata_i);
    end
  end

  assign cfg_rdata_o = 16'(cfg);

  // Masked faults never reach the steering logic
  assign active = fss_pkg::fss_fault_t'(fault_i & ~fault_mask_i);
  assign act = {cfg.pos_supply_undervolt_action, cfg.pos_supply_overvolt_action,
                cfg.neg_supply_undervolt_action, cfg.neg_supply_overvolt_action,
                cfg.trim_check_fail_action, cfg.config_check_fail_action,
                cfg.clock_watch_fail_action};

  // Low wins over high when faults disagree; reserved code is taken as low to fail safe
  always_comb begin
    any_low  = 1'b0;
    any_high = 1'b0;
    for (int i = 0; i < fss_pkg::FAULT_N; i++) begin
      if (active[i]) begin
        if (act[i] == fss_pkg::ACT_HIGH) begin
          any_high = 1'b1;
        end else if (act[i] != fss_pkg::ACT_NONE) begin
          any_low = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      gate_source_output_o <= 1'b0;
      gate_sink_output_o   <= 1'b1;
      safe_state_active_o  <= 1'b0;
    end else if (any_low) begin
      gate_source_output_o <= 1'b0;
      gate_sink_output_o   <= 1'b1;
      safe_state_active_o  <= 1'b1;
    end else if (any_high) begin
      gate_source_output_o <= 1'b1;
      gate_sink_output_o   <= 1'b0;
      safe_state_active_o  <= 1'b1;
    end else begin
      gate_source_output_o <= gate_cmd_i;
      gate_sink_output_o   <= ~gate_cmd_i;
      safe_state_active_o  <= 1'b0;
    end
  end

  // A new trigger restarts the hold from the full time
  always_comb begin
    if (clamp_trigger_i) begin
      next_clamp_cnt = hold_cycles(cfg.voltage_clamp_hold_sel);
    end else if (clamp_cnt != '0) begin
      next_clamp_cnt = clamp_cnt - 1'b1;
    end else begin
      next_clamp_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      clamp_cnt                 <= '0;
      collector_voltage_clamp_o <= 1'b0;
    end else begin
      clamp_cnt                 <= next_clamp_cnt;
      collector_voltage_clamp_o <= (next_clamp_cnt != '0);
    end
  end

  // Helper logic for checking the clamp run length
  logic [fss_pkg::CLAMP_CNT_W-1:0] run_len;
  logic [fss_pkg::CLAMP_CNT_W-1:0] hold_load;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      run_len   <= '0;
      hold_load <= '0;
    end else if (clamp_trigger_i) begin
      run_len   <= 7'h01;
      hold_load <= hold_cycles(cfg.voltage_clamp_hold_sel);
    end else if (collector_voltage_clamp_o) begin
      run_len   <= run_len + 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  chk_pos_uv_low: assert property (
    active.pos_uv && cfg.pos_supply_undervolt_action == fss_pkg::ACT_LOW
    |=> !gate_source_output_o && gate_sink_output_o && safe_state_active_o)
    else $error("pos undervolt did not force low");

  chk_pos_ov_high: assert property (
    active.pos_ov && cfg.pos_supply_overvolt_action == fss_pkg::ACT_HIGH && !any_low
    |=> gate_source_output_o && !gate_sink_output_o)
    else $error("pos overvolt did not force high");

  chk_neg_uv_high: assert property (
    active.neg_uv && cfg.neg_supply_undervolt_action == fss_pkg::ACT_HIGH && !any_low
    |=> gate_source_output_o && !gate_sink_output_o)
    else $error("neg undervolt did not force high");

  chk_neg_ov_none: assert property (
    active == 7'h08 && cfg.neg_supply_overvolt_action == fss_pkg::ACT_NONE
    |=> gate_source_output_o == $past(gate_cmd_i) && !safe_state_active_o)
    else $error("neg overvolt no-action altered outputs");

  chk_trim_rsvd_low: assert property (
    active.trim_crc && cfg.trim_check_fail_action == fss_pkg::ACT_RSVD
    |=> !gate_source_output_o && gate_sink_output_o)
    else $error("trim fault with reserved code not low");

  chk_cfg_crc_high: assert property (
    active == 7'h02 && cfg.config_check_fail_action == fss_pkg::ACT_HIGH
    |=> gate_source_output_o && !gate_sink_output_o && safe_state_active_o)
    else $error("config crc fault did not force high");

  chk_clamp_hold_len: assert property (
    $fell(collector_voltage_clamp_o) |-> $past(run_len) == hold_load)
    else $error("clamp hold length wrong");

  chk_clamp_start: assert property (
    clamp_trigger_i |=> collector_voltage_clamp_o [*8])
    else $error("clamp did not start or dropped early");

  chk_clk_mon_low: assert property (
    active.clk_mon && cfg.clock_watch_fail_action == fss_pkg::ACT_LOW
    |=> !gate_source_output_o && gate_sink_output_o)
    else $error("clock monitor fault did not force low");

  chk_reset_zero: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    !rst_b_i |=> cfg_rdata_o == 16'h0000 && !gate_source_output_o && gate_sink_output_o
                 && !safe_state_active_o && !collector_voltage_clamp_o)
    else $error("reset state not zero and low");

  chk_masked_ignored: assert property (
    fault_i == 7'h40 && fault_mask_i == 7'h40
    |=> gate_source_output_o == $past(gate_cmd_i) && !safe_state_active_o)
    else $error("masked fault applied a safe state");

  chk_write_readback: assert property (
    cfg_wr_i |=> cfg_rdata_o == $past(cfg_wdata_i))
    else $error("register write not stored");

  chk_pos_uv_none: assert property (
    active == 7'h40 && cfg.pos_supply_undervolt_action == fss_pkg::ACT_NONE
    |=> gate_source_output_o == $past(gate_cmd_i) && !safe_state_active_o)
    else $error("pos undervolt no-action altered outputs");

  chk_neg_ov_low: assert property (
    active.neg_ov && cfg.neg_supply_overvolt_action == fss_pkg::ACT_LOW
    |=> !gate_source_output_o && gate_sink_output_o && safe_state_active_o)
    else $error("neg overvolt did not force low");

  chk_trim_high: assert property (
    active == 7'h04 && cfg.trim_check_fail_action == fss_pkg::ACT_HIGH
    |=> gate_source_output_o && !gate_sink_output_o && safe_state_active_o)
    else $error("trim fault did not force high");

  chk_clk_mon_high: assert property (
    active == 7'h01 && cfg.clock_watch_fail_action == fss_pkg::ACT_HIGH
    |=> gate_source_output_o && !gate_sink_output_o && safe_state_active_o)
    else $error("clock monitor fault did not force high");

  chk_no_fault_follow: assert property (
    active == 7'h00
    |=> gate_source_output_o == $past(gate_cmd_i) && gate_sink_output_o != $past(gate_cmd_i) && !safe_state_active_o)
    else $error("outputs did not follow the drive command");

  chk_clamp_idle: assert property (
    !clamp_trigger_i && clamp_cnt == '0 |=> !collector_voltage_clamp_o)
    else $error("clamp active without a running hold");

  cov_safe_low:  cover property (any_low ##1 safe_state_active_o && gate_sink_output_o);
  cov_safe_high: cover property (any_high && !any_low ##1 gate_source_output_o);
  cov_clamp_max: cover property ($fell(collector_voltage_clamp_o) && hold_load == 7'h50);
  cov_masked:    cover property ((fault_i & fault_mask_i) != 7'h00 && active == 7'h00);

endmodule

// *** logic/fss_pkg.sv ***
// Constants, field layout and carrier types for the fault safe-state configuration block.
// Assumes a 200 MHz system clock; all users reference names as fss_pkg::name.
package fss_pkg;

  localparam int          CFG_W          = 16;
  localparam logic [15:0] CFG_RESET      = 16'h0000;

  // Field positions (low bit of each 2-bit field)
  localparam int POS_UV_LSB = 14;
  localparam int POS_OV_LSB = 12;
  localparam int NEG_UV_LSB = 10;
  localparam int NEG_OV_LSB = 8;
  localparam int TRIM_LSB   = 6;
  localparam int CFGC_LSB   = 4;
  localparam int CLAMP_LSB  = 2;
  localparam int CLKW_LSB   = 0;

  // Fault-state action codes
  localparam logic [1:0] ACT_LOW  = 2'h0;
  localparam logic [1:0] ACT_HIGH = 2'h1;
  localparam logic [1:0] ACT_RSVD = 2'h2;
  localparam logic [1:0] ACT_NONE = 2'h3;

  // Clamp hold timing
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int CLAMP_STEP_NS  = 100;
  localparam int CLAMP_STEP_CYC = (CLAMP_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLAMP_CNT_W    = 7;
  localparam int FAULT_N        = 7;

  typedef struct packed {
    logic [1:0] pos_supply_undervolt_action;
    logic [1:0] pos_supply_overvolt_action;
    logic [1:0] neg_supply_undervolt_action;
    logic [1:0] neg_supply_overvolt_action;
    logic [1:0] trim_check_fail_action;
    logic [1:0] config_check_fail_action;
    logic [1:0] voltage_clamp_hold_sel;
    logic [1:0] clock_watch_fail_action;
  } fss_cfg_t;

  // Same order as the action fields, clamp excluded
  typedef struct packed {
    logic pos_uv;
    logic pos_ov;
    logic neg_uv;
    logic neg_ov;
    logic trim_crc;
    logic cfg_crc;
    logic clk_mon;
  } fss_fault_t;

endpackage
